/* pkg/csrb_pkg.sv */
`default_nettype none
package csrb_pkg;
  localparam logic [7:0] ADDR_INDIRECT_WINDOW = 8'h00;
  localparam logic [7:0] ADDR_TIMER0_COUNT = 8'h01;
  localparam logic [7:0] ADDR_PC_LOW_BYTE = 8'h02;
  localparam logic [7:0] ADDR_CORE_STATUS = 8'h03;
  localparam logic [7:0] ADDR_INDIRECT_POINTER = 8'h04;
  localparam logic [7:0] ADDR_PORT_A_DATA = 8'h05;
  localparam logic [7:0] ADDR_PORT_B_DATA = 8'h06;
  localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h0a;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] ADDR_OPTION_CONFIG = 8'h81;
  localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h86;
  localparam logic [7:0] ADDR_IRQ_EVENT_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EVENT_MASK = 8'h0d;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h0e;
  localparam logic [7:0] ADDR_TIMER_OVERFLOW = 8'h0f;
  localparam logic [7:0] BANK_BIT = 8'h80;
  localparam logic [6:0] LOW_ADDR_MASK = 7'h7f;
  localparam int AVL_ADDR_W = 10;
  localparam int BUS_BYTE_SHIFT = 2;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_ONES = 8'hff;
  localparam logic [4:0] PORT_A_DIR_RESET = 5'h1f;
  localparam logic [4:0] PC_HIGH_RESET = 5'h00;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h1f;
  localparam logic [7:0] STATUS_KEEP_FLAGS = 8'h07;
  localparam logic [7:0] INTERRUPT_CONTROL_KEEP_MASK = 8'h01;
  localparam logic [7:0] INTERRUPT_CONTROL_IMPL_MASK = 8'hbf;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'he7;
  localparam int ST_BANK_LOW = 5;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_POWERDOWN = 3;
  localparam int IC_GLOBAL = 7;
  localparam int IC_TIMER_EN = 5;
  localparam int IC_EXT_EN = 4;
  localparam int IC_PIN_EN = 3;
  localparam int IC_TIMER_FLAG = 2;
  localparam int IC_EXT_FLAG = 1;
  localparam int IC_PIN_FLAG = 0;
  localparam int OPT_PULLUP_DIS_N = 7;
  localparam int OPT_EDGE = 6;
  localparam int EV_TIMER = 0;
  localparam int EV_EXT = 1;
  localparam int EV_PIN = 2;
  localparam int EV_W = 3;
  localparam int PORT_A_W = 5;
  localparam logic [1:0] CLK_DIV_LAST = 2'h1;
  localparam int RC_CAUSE_POR = 0;
  localparam int RC_CAUSE_MASTER_CLEAR_N = 1;
  localparam int RC_CAUSE_WDT = 2;

  typedef struct packed {
    logic read;
    logic write;
    logic [AVL_ADDR_W-1:0] address;
    logic [31:0] writedata;
  } csrb_bus_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } csrb_mem_req_t;
endpackage
`default_nettype wire

/* hw/csrb_clk_div.sv */
`default_nettype none
module csrb_clk_div
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // oscillator and output
  input wire logic osc_input,
  input wire logic rc_mode,
  output logic instr_clock_out
);
  typedef struct packed {
    logic osc_q;
    logic [1:0] half_cnt;
    logic clk_q;
  } csrb_div_state_t;
  csrb_div_state_t st;
  csrb_div_state_t next_st;

  // toggle every second osc rising edge: output at quarter rate
  always_comb
  begin
    next_st = st;
    next_st.osc_q = osc_input;
    if (osc_input && !st.osc_q)
    begin
      if (st.half_cnt == csrb_pkg::CLK_DIV_LAST)
      begin
        next_st.half_cnt = 2'h0;
        next_st.clk_q = ~st.clk_q; // RL14
      end
      else
      begin
        next_st.half_cnt = st.half_cnt + 2'h1;
      end
    end
    if (!rc_mode)
    begin
      next_st.clk_q = 1'b0;
      next_st.half_cnt = 2'h0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign instr_clock_out = st.clk_q;
endmodule
`default_nettype wire

/* hw/csrb_core_regs.sv */
// How it works
// [RL1] window address accesses data memory at pointer address, no own storage
// [RL2] window, pc low, status, pointer, pc high, irq control mirror both banks
// [RL3] 5-bit pc high latch feeds pc bits 12..8, cleared on any reset
// [RL4] port write loads output latch; port read returns pin levels
// [RL5] unimplemented addresses and bits read as zero
// [RL6] power-on reset and other resets load different values
// [RL7] status holds bank, flags, zero, digit carry, carry with given resets
// [RL8] software keeps indirect bank and high bank bits cleared
// [RL9] option config in bank 1, all ones on reset
// [RL10] port direction registers reset to all ones, pins inputs
// [RL11] irq control layout, bit 6 unused, reset 0-00 000x / 0-00 000u
// [RL12] timer, pointer, port b data undefined at power-on, kept otherwise
// [RL13] pc low and window read zero after any reset; the window reads data memory at the pointer address instead
// [RL14] rc mode instruction clock is osc input divided by four
// [RL15] master clear low holds device in reset
// [RL16] option bit enables weak pull-ups together on all port b pins whose direction bit is set (inputs)
// [RL17] port b bit 0 external irq, bits 4..7 raise irq on change
// [RL18] low bank select bit chooses bank 0 or bank 1 direct map
// [RL19] single synchronous access, written value seen by next access
`default_nettype none
module csrb_core_regs
#(
  parameter int PORT_B_W = 8
)
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic master_clear_n,
  input wire logic wdt_timeout,
  // avalon-mm slave
  input wire logic [csrb_pkg::AVL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // data memory for indirect access
  output csrb_pkg::csrb_mem_req_t mem_req,
  output logic mem_valid,
  input wire logic [7:0] mem_rdata,
  // core status inputs
  input wire logic [2:0] alu_flags,
  input wire logic timer_overflow,
  // ports
  input wire logic [csrb_pkg::PORT_A_W-1:0] port_a_pin_in,
  output logic [csrb_pkg::PORT_A_W-1:0] port_a_pin_out,
  output logic [csrb_pkg::PORT_A_W-1:0] port_a_pin_oe,
  input wire logic [PORT_B_W-1:0] port_b_pin_in,
  output logic [PORT_B_W-1:0] port_b_pin_out,
  output logic [PORT_B_W-1:0] port_b_pin_oe,
  output logic [PORT_B_W-1:0] port_b_pullup_en,
  // program counter upper bits and config
  output logic [4:0] pc_upper,
  output logic [7:0] option_out,
  // clocking
  input wire logic osc_input,
  input wire logic rc_mode,
  output logic instr_clock_out,
  // interrupts
  output logic core_irq,
  output logic irq
);
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    MEM = 2'b01,
    DONE = 2'b10
  } csrb_phase_t;

  typedef struct packed {
    csrb_phase_t phase;
    logic [7:0] rdata;
    logic [7:0] timer0;
    logic [7:0] pointer;
    logic [7:0] status;
    logic [4:0] pc_high;
    logic [7:0] interrupt_control;
    logic [7:0] option;
    logic [4:0] port_a_lat;
    logic [PORT_B_W-1:0] port_b_lat;
    logic [4:0] port_a_dir;
    logic [PORT_B_W-1:0] port_b_dir;
    logic [PORT_B_W-1:0] pins_b_q;
    logic [csrb_pkg::EV_W-1:0] ev_status;
    logic [csrb_pkg::EV_W-1:0] ev_mask;
    logic [2:0] cause;
    logic waitreq;
  } csrb_state_t;

  csrb_state_t st;
  csrb_state_t next_st;
  csrb_pkg::csrb_mem_req_t next_mem;
  logic [7:0] addr_full;
  logic [7:0] reg_addr;
  logic [7:0] wbyte;
  logic other_rst;
  logic pin_change;
  logic ext_edge;
  logic [csrb_pkg::EV_W-1:0] ev_set;

  function automatic logic [7:0] map_addr(input logic [7:0] a, input logic bank);
    logic [6:0] low;
    low = a[6:0] & csrb_pkg::LOW_ADDR_MASK;
    case ({1'b0, low})
      csrb_pkg::ADDR_INDIRECT_WINDOW, csrb_pkg::ADDR_PC_LOW_BYTE, csrb_pkg::ADDR_CORE_STATUS,
      csrb_pkg::ADDR_INDIRECT_POINTER, csrb_pkg::ADDR_PC_HIGH_LATCH, csrb_pkg::ADDR_INTERRUPT_CONTROL:
        map_addr = {1'b0, low}; // RL2
      default:
        map_addr = bank ? (csrb_pkg::BANK_BIT | {1'b0, low}) : {1'b0, low}; // RL18
    endcase
  endfunction

  assign addr_full = avs_address[csrb_pkg::BUS_BYTE_SHIFT +: 8];
  assign reg_addr = map_addr(addr_full, st.status[csrb_pkg::ST_BANK_LOW]);
  assign wbyte = avs_writedata[7:0];
  assign other_rst = !master_clear_n || wdt_timeout; // RL15
  assign pin_change = |(st.pins_b_q[PORT_B_W-1:4] ^ port_b_pin_in[PORT_B_W-1:4]); // RL17
  assign ext_edge = st.option[csrb_pkg::OPT_EDGE] ? (port_b_pin_in[0] && !st.pins_b_q[0])
    : (!port_b_pin_in[0] && st.pins_b_q[0]); // RL17
  assign ev_set = {pin_change, ext_edge, timer_overflow};

  always_comb
  begin
    next_st = st;
    next_mem = mem_req;
    next_st.pins_b_q = port_b_pin_in;
    // hardware event flags: set wins over a software clear
    if (avs_write && st.phase == IDLE && avs_byteenable[0] && reg_addr == csrb_pkg::ADDR_INTERRUPT_CONTROL)
      next_st.interrupt_control = wbyte & csrb_pkg::INTERRUPT_CONTROL_IMPL_MASK;
    if (avs_write && st.phase == IDLE && avs_byteenable[0] && reg_addr == csrb_pkg::ADDR_IRQ_EVENT_STATUS)
      next_st.ev_status = st.ev_status & ~wbyte[csrb_pkg::EV_W-1:0];
    next_st.ev_status = next_st.ev_status | ev_set;
    if (timer_overflow)
      next_st.interrupt_control[csrb_pkg::IC_TIMER_FLAG] = 1'b1;
    if (ext_edge)
      next_st.interrupt_control[csrb_pkg::IC_EXT_FLAG] = 1'b1; // RL17
    if (pin_change)
      next_st.interrupt_control[csrb_pkg::IC_PIN_FLAG] = 1'b1; // RL17
    next_st.status[2:0] = alu_flags;
    case (st.phase)
      IDLE:
      begin
        if (avs_read || avs_write)
        begin
          next_st.phase = DONE; // RL19
          next_st.rdata = csrb_pkg::RESET_ZERO; // RL5
          if (reg_addr == csrb_pkg::ADDR_INDIRECT_WINDOW)
          begin
            next_mem.addr = st.pointer; // RL1
            next_mem.wdata = wbyte;
            next_mem.we = avs_write && avs_byteenable[0];
            next_st.phase = MEM;
          end
          else if (avs_read)
          begin
            case (reg_addr)
              csrb_pkg::ADDR_TIMER0_COUNT: next_st.rdata = st.timer0;
              csrb_pkg::ADDR_PC_LOW_BYTE: next_st.rdata = csrb_pkg::RESET_ZERO; // RL13
              csrb_pkg::ADDR_CORE_STATUS: next_st.rdata = st.status;
              csrb_pkg::ADDR_INDIRECT_POINTER: next_st.rdata = st.pointer;
              csrb_pkg::ADDR_PORT_A_DATA: next_st.rdata = {3'h0, port_a_pin_in}; // RL4
              csrb_pkg::ADDR_PORT_B_DATA: next_st.rdata = port_b_pin_in[7:0]; // RL4
              csrb_pkg::ADDR_PC_HIGH_LATCH: next_st.rdata = {3'h0, st.pc_high}; // RL3
              csrb_pkg::ADDR_INTERRUPT_CONTROL: next_st.rdata = st.interrupt_control; // RL11
              csrb_pkg::ADDR_IRQ_EVENT_STATUS: next_st.rdata = {5'h0, st.ev_status};
              csrb_pkg::ADDR_IRQ_EVENT_MASK: next_st.rdata = {5'h0, st.ev_mask};
              csrb_pkg::ADDR_RESET_CAUSE: next_st.rdata = {5'h0, st.cause};
              csrb_pkg::ADDR_OPTION_CONFIG: next_st.rdata = st.option; // RL9
              csrb_pkg::ADDR_PORT_A_DIRECTION: next_st.rdata = {3'h0, st.port_a_dir}; // RL5
              csrb_pkg::ADDR_PORT_B_DIRECTION: next_st.rdata = st.port_b_dir;
              default: next_st.rdata = csrb_pkg::RESET_ZERO; // RL5
            endcase
          end
          else if (avs_byteenable[0])
          begin
            case (reg_addr)
              csrb_pkg::ADDR_TIMER0_COUNT: next_st.timer0 = wbyte;
              csrb_pkg::ADDR_CORE_STATUS:
                next_st.status = (wbyte & csrb_pkg::STATUS_WRITE_MASK) | (st.status & ~csrb_pkg::STATUS_WRITE_MASK);
              csrb_pkg::ADDR_INDIRECT_POINTER: next_st.pointer = wbyte;
              csrb_pkg::ADDR_PORT_A_DATA: next_st.port_a_lat = wbyte[4:0]; // RL4
              csrb_pkg::ADDR_PORT_B_DATA: next_st.port_b_lat = wbyte; // RL4
              csrb_pkg::ADDR_PC_HIGH_LATCH: next_st.pc_high = wbyte[4:0]; // RL3
              csrb_pkg::ADDR_IRQ_EVENT_MASK: next_st.ev_mask = wbyte[csrb_pkg::EV_W-1:0];
              csrb_pkg::ADDR_OPTION_CONFIG: next_st.option = wbyte; // RL9
              csrb_pkg::ADDR_PORT_A_DIRECTION: next_st.port_a_dir = wbyte[4:0];
              csrb_pkg::ADDR_PORT_B_DIRECTION: next_st.port_b_dir = wbyte;
              default: next_st.phase = DONE;
            endcase
          end
        end
      end
      MEM:
      begin
        next_mem.we = 1'b0;
        next_st.rdata = mem_rdata; // RL1
        next_st.phase = DONE;
      end
      DONE:
      begin
        next_st.phase = IDLE;
      end
      default:
      begin
        next_st.phase = IDLE;
      end
    endcase
    next_st.waitreq = (next_st.phase != DONE); // RL19
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      // power-on: values marked unknown are zero here
      st <= '0; // RL6
      st.status <= csrb_pkg::STATUS_POR; // RL7
      st.option <= csrb_pkg::RESET_ONES; // RL9
      st.port_a_dir <= csrb_pkg::PORT_A_DIR_RESET; // RL10
      st.port_b_dir <= '1; // RL10
      st.cause <= 3'(1 << csrb_pkg::RC_CAUSE_POR); // RL6
      st.waitreq <= 1'b1;
      st.pins_b_q <= port_b_pin_in; // RL17
      mem_req <= '0;
      mem_valid <= 1'b0;
    end
    else if (other_rst)
    begin
      // timer0, pointer, port latches kept
      st.phase <= IDLE; // RL12
      st.rdata <= csrb_pkg::RESET_ZERO; // RL13
      st.status <= st.status & csrb_pkg::STATUS_KEEP_FLAGS | {3'h0, ~wdt_timeout, 4'h0}; // RL7
      st.pc_high <= csrb_pkg::PC_HIGH_RESET; // RL3
      st.interrupt_control <= st.interrupt_control & csrb_pkg::INTERRUPT_CONTROL_KEEP_MASK; // RL11
      st.option <= csrb_pkg::RESET_ONES; // RL9
      st.port_a_dir <= csrb_pkg::PORT_A_DIR_RESET; // RL10
      st.port_b_dir <= '1; // RL10
      st.cause <= {wdt_timeout, !master_clear_n, 1'b0}; // RL6
      st.pins_b_q <= port_b_pin_in;
      st.waitreq <= 1'b1;
      mem_req <= '0;
      mem_valid <= 1'b0;
    end
    else
    begin
      st <= next_st;
      mem_req <= next_mem;
      mem_valid <= (st.phase == IDLE) && (avs_read || avs_write) && reg_addr == csrb_pkg::ADDR_INDIRECT_WINDOW;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      port_a_pin_out <= '0;
      port_a_pin_oe <= '0;
      port_b_pin_out <= '0;
      port_b_pin_oe <= '0;
      port_b_pullup_en <= '0;
      pc_upper <= '0;
      option_out <= csrb_pkg::RESET_ONES;
      core_irq <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      port_a_pin_out <= st.port_a_lat;
      port_a_pin_oe <= ~st.port_a_dir; // RL10
      port_b_pin_out <= st.port_b_lat;
      port_b_pin_oe <= ~st.port_b_dir;
      port_b_pullup_en <= {PORT_B_W{~st.option[csrb_pkg::OPT_PULLUP_DIS_N]}} & st.port_b_dir; // RL16
      pc_upper <= st.pc_high; // RL3
      option_out <= st.option;
      core_irq <= st.interrupt_control[csrb_pkg::IC_GLOBAL] &&
        |(st.interrupt_control[csrb_pkg::IC_TIMER_EN:csrb_pkg::IC_PIN_EN] & st.interrupt_control[csrb_pkg::IC_TIMER_FLAG:0]);
      irq <= |(st.ev_status & ~st.ev_mask);
    end
  end

  assign avs_readdata = {24'h0, st.rdata};
  assign avs_waitrequest = st.waitreq; // RL19

  csrb_clk_div u_clk_div
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .osc_input(osc_input),
    .rc_mode(rc_mode),
    .instr_clock_out(instr_clock_out)
  );
endmodule
`default_nettype wire

/* tb/csrb_core_regs_chk.sv */
`default_nettype none
module csrb_core_regs_chk
#(
  parameter int PORT_B_W = 8
)
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic master_clear_n,
  input wire logic wdt_timeout,
  // bus
  input wire logic [csrb_pkg::AVL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // ports and config
  input wire logic [csrb_pkg::PORT_A_W-1:0] port_a_pin_oe,
  input wire logic [PORT_B_W-1:0] port_b_pin_oe,
  input wire logic [PORT_B_W-1:0] port_b_pullup_en,
  input wire logic [4:0] pc_upper,
  input wire logic [7:0] option_out,
  input wire logic rc_mode,
  input wire logic instr_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  chk_wait_bound: assert property (s_req |-> ##[1:2] !avs_waitrequest)
    else $error("request not answered in time");
  chk_wait_pulse: assert property (s_done |=> avs_waitrequest)
    else $error("answer held too long");
  chk_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[8:2] inside {7'h07, 7'h08, 7'h09}
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_por_values: assert property ($fell(rst) |-> option_out == 8'hff && pc_upper == 5'h00
    && port_a_pin_oe == '0 && port_b_pin_oe == '0)
    else $error("power-on values wrong");
  chk_other_reset: assert property (!master_clear_n || wdt_timeout
    |-> ##2 option_out == 8'hff && pc_upper == 5'h00 && port_b_pin_oe == '0)
    else $error("other reset values wrong");
  chk_pullup_rule: assert property ($stable(option_out) && $stable(port_b_pin_oe)
    |-> port_b_pullup_en == (option_out[7] ? '0 : ~port_b_pin_oe))
    else $error("pull-up enables wrong");
  chk_rc_off: assert property (!rc_mode ##1 !rc_mode |-> !instr_clock_out)
    else $error("clock output runs outside rc mode");
  chk_pch_write: assert property (avs_write && !avs_waitrequest && avs_address[8:2] == 7'h0a
    |=> pc_upper == $past(avs_writedata[4:0]))
    else $error("pc high latch not loaded");
endmodule
`default_nettype wire

/* tb/csrb_mem_model.sv */
`default_nettype none
module csrb_mem_model
(
  // clock
  input wire logic clk_sys,
  // memory request
  input wire csrb_pkg::csrb_mem_req_t mem_req,
  input wire logic mem_valid,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  // write lands at the edge closing the request
  always @(posedge clk_sys)
  begin
    if (mem_valid && mem_req.we)
      mem[mem_req.addr] <= mem_req.wdata;
  end
  // read stands while the request stands; inverted outside it so a late sample shows
  assign mem_rdata = mem_valid ? mem[mem_req.addr] : ~mem[mem_req.addr];
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic wr; logic [7:0] idx; logic [7:0] val;} csrb_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic master_clear_n = 1'b1;
  logic wdt_timeout = 1'b0;
  logic [csrb_pkg::AVL_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  csrb_pkg::csrb_mem_req_t mem_req;
  logic mem_valid;
  logic [7:0] mem_rdata;
  logic timer_overflow = 1'b0;
  logic [4:0] port_a_pin_in = 5'h0a;
  logic [4:0] port_a_pin_out, port_a_pin_oe, pc_upper;
  logic [7:0] port_b_pin_in = 8'h3c;
  logic [7:0] port_b_pin_out, port_b_pin_oe, port_b_pullup_en, option_out, rd;
  logic osc_input = 1'b0;
  logic rc_mode = 1'b0;
  logic instr_clock_out, core_irq, irq;
  int failures = 0;
  int samples_checked = 0;
  int n;
  csrb_row_t rows [0:27] = '{
    '{1'b0, 8'h03, 8'h1d}, '{1'b0, 8'h02, 8'h00}, '{1'b0, 8'h0a, 8'h00},
    '{1'b0, 8'h0b, 8'h00}, '{1'b0, 8'h07, 8'h00}, '{1'b0, 8'h05, 8'h0a},
    '{1'b0, 8'h06, 8'h3c}, '{1'b1, 8'h03, 8'h20}, '{1'b0, 8'h83, 8'h3d},
    '{1'b0, 8'h81, 8'hff}, '{1'b0, 8'h85, 8'h1f}, '{1'b0, 8'h86, 8'hff},
    '{1'b0, 8'h89, 8'h00}, '{1'b1, 8'h85, 8'h00}, '{1'b1, 8'h0a, 8'hff},
    '{1'b0, 8'h8a, 8'h1f}, '{1'b1, 8'h8b, 8'hff}, '{1'b0, 8'h0b, 8'hbf},
    '{1'b1, 8'h03, 8'h00}, '{1'b1, 8'h01, 8'h5a}, '{1'b0, 8'h01, 8'h5a},
    '{1'b1, 8'h04, 8'h40}, '{1'b0, 8'h84, 8'h40}, '{1'b1, 8'h00, 8'h77},
    '{1'b0, 8'h80, 8'h77}, '{1'b0, 8'h04, 8'h40}, '{1'b1, 8'h05, 8'hff}, '{1'b1, 8'h06, 8'ha5}};
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) osc_input <= rc_mode ? ~osc_input : 1'b0;
  csrb_core_regs dut_u (.clk_sys(clk_sys), .rst(rst), .master_clear_n(master_clear_n), .wdt_timeout(wdt_timeout),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
    .mem_valid(mem_valid), .mem_rdata(mem_rdata), .alu_flags(3'h5), .timer_overflow(timer_overflow),
    .port_a_pin_in(port_a_pin_in), .port_a_pin_out(port_a_pin_out), .port_a_pin_oe(port_a_pin_oe),
    .port_b_pin_in(port_b_pin_in), .port_b_pin_out(port_b_pin_out), .port_b_pin_oe(port_b_pin_oe),
    .port_b_pullup_en(port_b_pullup_en), .pc_upper(pc_upper), .option_out(option_out), .osc_input(osc_input),
    .rc_mode(rc_mode), .instr_clock_out(instr_clock_out), .core_irq(core_irq), .irq(irq));
  csrb_mem_model mem_u (.clk_sys(clk_sys), .mem_req(mem_req), .mem_valid(mem_valid), .mem_rdata(mem_rdata));
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request stands until the edge that samples waitrequest low; read data taken there, then one idle edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, wd};
    avs_read <= ~wr;
    avs_write <= wr;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (k == 50)
    begin
      failures++;
      end_sim();
    end
    else
    begin
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    cmp(rd, exp);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic rise_wait(output int c);
    c = 0;
    while (instr_clock_out !== 1'b0 && c < 40)
    begin
      @(negedge clk_sys);
      c++;
    end
    while (instr_clock_out !== 1'b1 && c < 40)
    begin
      @(negedge clk_sys);
      c++;
    end
    if (c >= 40)
    begin
      failures++;
      end_sim();
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 28; i++)
    begin
      if (rows[i].wr)
        bus(1'b1, rows[i].idx, rows[i].val);
      else
        rdc(rows[i].idx, rows[i].val);
    end
    $display("register table test done");
    settle(1);
    cmp({3'h0, port_a_pin_out}, 8'h1f);
    cmp({3'h0, port_a_pin_oe}, 8'h1f);
    cmp({3'h0, pc_upper}, 8'h1f);
    cmp(port_b_pullup_en, 8'h00);
    cmp(port_b_pin_out, 8'ha5);
    cmp({7'h0, core_irq}, 8'h01);
    @(posedge clk_sys);
    bus(1'b1, 8'h03, 8'h20);
    bus(1'b1, 8'h81, 8'h7f);
    bus(1'b1, 8'h03, 8'h00);
    bus(1'b1, 8'h0d, 8'h07);
    timer_overflow <= 1'b1;
    port_b_pin_in <= 8'h2d;
    @(posedge clk_sys);
    timer_overflow <= 1'b0;
    settle(2);
    cmp(port_b_pullup_en, 8'hff);
    cmp(option_out, 8'h7f);
    cmp({7'h0, irq}, 8'h00);
    @(posedge clk_sys);
    rdc(8'h0c, 8'h07);
    bus(1'b1, 8'h0d, 8'h00);
    settle(1);
    cmp({7'h0, irq}, 8'h01);
    @(posedge clk_sys);
    bus(1'b1, 8'h0c, 8'h07);
    rdc(8'h0c, 8'h00);
    settle(1);
    cmp({7'h0, irq}, 8'h00);
    $display("port and interrupt test done");
    @(posedge clk_sys);
    master_clear_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    master_clear_n <= 1'b1;
    @(posedge clk_sys);
    rdc(8'h01, 8'h5a);
    rdc(8'h04, 8'h40);
    rdc(8'h0a, 8'h00);
    rdc(8'h03, 8'h15);
    rdc(8'h0b, 8'h01);
    rdc(8'h02, 8'h00);
    rdc(8'h0e, 8'h02);
    settle(1);
    cmp({7'h0, core_irq}, 8'h00);
    @(posedge clk_sys);
    wdt_timeout <= 1'b1;
    @(posedge clk_sys);
    wdt_timeout <= 1'b0;
    @(posedge clk_sys);
    rdc(8'h03, 8'h05);
    rdc(8'h0e, 8'h04);
    $display("other reset test done");
    rc_mode <= 1'b1;
    rise_wait(n);
    rise_wait(n);
    cmp(n[7:0], 8'h08);
    @(posedge clk_sys);
    rc_mode <= 1'b0;
    rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc(8'h04, 8'h00);
    rdc(8'h03, 8'h1d);
    rdc(8'h0e, 8'h01);
    $display("clock and power-on test done");
    end_sim();
  end
endmodule
bind csrb_core_regs csrb_core_regs_chk #(.PORT_B_W(PORT_B_W)) chk_u (.clk_sys(clk_sys), .rst(rst),
  .master_clear_n(master_clear_n), .wdt_timeout(wdt_timeout), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .port_a_pin_oe(port_a_pin_oe), .port_b_pin_oe(port_b_pin_oe),
  .port_b_pullup_en(port_b_pullup_en), .pc_upper(pc_upper), .option_out(option_out), .rc_mode(rc_mode),
  .instr_clock_out(instr_clock_out));
`default_nettype wire
